// File: sim/port_chk_sva.sv
// Purpose: pin checks for the burst SRAM port
// Assumes: bound to the top module
// Notes: sleep sub-states are hidden, judged by o_sleeping
`timescale 1ns/100ps
module port_chk (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_clock_qualify_n,
	input wire logic i_chip_sel_a_n,
	input wire logic i_chip_sel_b,
	input wire logic i_chip_sel_c_n,
	input wire logic i_advance_or_load,
	input wire logic i_write_n,
	input wire logic i_out_enable_n,
	input wire logic i_sleep_request,
	input wire logic [31:0] o_dq,
	input wire logic o_dq_oe_n,
	input wire logic [3:0] o_parity_bus,
	input wire logic o_parity_bus_oe_n,
	input wire logic o_sleeping,
	input wire logic o_wr_buf_ready
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	wire logic sel = !i_chip_sel_a_n && i_chip_sel_b && !i_chip_sel_c_n;
	wire logic ld = !i_clock_qualify_n && !i_advance_or_load && !i_sleep_request && !o_sleeping;
	wire logic off = o_dq_oe_n && o_parity_bus_oe_n;
	sequence s_rd; ld && sel && i_write_n; endsequence
	sequence s_wr; ld && sel && !i_write_n; endsequence
	property p_rst; $fell(i_rst) |-> off && !o_sleeping && o_wr_buf_ready; endproperty
	property p_desel; ld && !sel |=> off; endproperty
	property p_wr; s_wr |=> off; endproperty
	// the continuation beat shows write_n high, yet must stay a write
	property p_dir; s_wr ##1 (!i_clock_qualify_n && i_advance_or_load) |=> off; endproperty
	property p_rd; (!i_out_enable_n)[*3] ##0 s_rd |=> !o_dq_oe_n && !o_parity_bus_oe_n; endproperty
	property p_oe; i_out_enable_n[*3] |=> off; endproperty
	property p_stall; i_clock_qualify_n |=> $stable(o_dq) && $stable(o_parity_bus); endproperty
	property p_slp; i_sleep_request[*8] |=> o_sleeping; endproperty
	a_rst: assert property (p_rst) else $error("bad reset state");
	a_desel: assert property (p_desel) else $error("drive kept");
	a_wr: assert property (p_wr) else $error("write phase driven");
	a_dir: assert property (p_dir) else $error("burst direction lost");
	a_rd: assert property (p_rd) else $error("read not driven");
	a_oe: assert property (p_oe) else $error("drive without enable");
	a_stall: assert property (p_stall) else $error("stalled edge moved data");
	a_slp: assert property (p_slp) else $error("sleep not entered");
endmodule
bind flow_through_burst_sram_port port_chk chk (.*);

// File: sim/sram_master.sv
// Purpose: bus master model for the SRAM port pins
// Assumes: pins change 1 ns after the edge
// Notes: idle data toggles so stale data never looks valid
`timescale 1ns/100ps
module sram_master (
	input wire logic i_sys_clk,
	output logic o_qual_n,
	output logic [2:0] o_sel,
	output logic o_aol,
	output logic o_write_n,
	output logic [3:0] o_bw_n,
	output logic [9:0] o_addr,
	output logic o_oe_n,
	output logic o_sleep,
	output logic [35:0] o_wdata
);
	logic due = 1'b0;
	logic [35:0] pend = '0;
	initial begin
		{o_qual_n, o_sel, o_aol, o_write_n, o_bw_n} = 10'h15f;
		{o_addr, o_oe_n, o_sleep} = '0;
		o_wdata = '0;
	end
	task automatic cmd(input logic ld, input logic on, input logic wr,
		input logic [3:0] bw, input logic [9:0] a, input logic [35:0] d);
		@(posedge i_sys_clk);
		#1;
		o_wdata = due ? pend : ~o_wdata;
		o_qual_n = 1'b0;
		o_aol = !ld;
		o_sel = on ? 3'b010 : 3'b101;
		o_write_n = !(wr && ld);
		o_bw_n = bw;
		o_addr = a;
		pend = d;
		due = wr;
	endtask
	// a stalled edge carries a deselect, so an edge that is not ignored shows
	task automatic stall;
		@(posedge i_sys_clk);
		#1;
		o_qual_n = 1'b1;
		o_aol = 1'b0;
		o_sel = 3'b101;
	endtask
	task automatic pins(input logic oe_n, input logic sleep);
		o_oe_n = oe_n;
		o_sleep = sleep;
	endtask
endmodule

// File: sim/tb.sv
// Purpose: self-checking bench for the burst SRAM port
// Assumes: 4 ns clock, reset held 20 cycles
// Notes: the bench resolves the shared data lines
`timescale 1ns/100ps
module tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic mode = 1'b0;
	int err_total = 0;
	int n_tests = 0;
	int cyc = 0;
	wire logic qn, aol, wn, oen, slp, dq_oe_n, par_oe_n, sleeping, buf_rdy;
	wire logic [2:0] sel;
	wire logic [3:0] bw, par;
	wire logic [9:0] addr;
	wire logic [31:0] dq;
	wire logic [35:0] wdat, bus;
	wire logic [36:0] q = {dq_oe_n, par, dq};
	assign bus = {par_oe_n ? wdat[35:32] : par, dq_oe_n ? wdat[31:0] : dq};
	always #2 clk = ~clk;
	sram_master m (.i_sys_clk(clk), .o_qual_n(qn), .o_sel(sel), .o_aol(aol), .o_write_n(wn),
		.o_bw_n(bw), .o_addr(addr), .o_oe_n(oen), .o_sleep(slp), .o_wdata(wdat));
	flow_through_burst_sram_port uut (.i_sys_clk(clk), .i_rst(rst), .i_clock_qualify_n(qn),
		.i_chip_sel_a_n(sel[2]), .i_chip_sel_b(sel[1]), .i_chip_sel_c_n(sel[0]),
		.i_advance_or_load(aol), .i_write_n(wn), .i_byte_write_sel_n(bw), .i_addr(addr),
		.i_out_enable_n(oen), .i_sleep_request(slp), .i_burst_order(mode),
		.i_dq(bus[31:0]), .o_dq(dq), .o_dq_oe_n(dq_oe_n), .i_parity_bus(bus[35:32]),
		.o_parity_bus(par), .o_parity_bus_oe_n(par_oe_n), .o_sleeping(sleeping),
		.o_wr_buf_ready(buf_rdy));
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			err_total++;
			wrap_up;
		end
	end
	function automatic logic [35:0] dv(input logic [9:0] a);
		return {a[3:0], 22'h2a5a3, a};
	endfunction
	task automatic check(input string what, input logic [36:0] exp, input logic [36:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic t_burst(input logic [9:0] a, input logic il);
		logic [1:0] lo;
		mode = il;
		for (int i = 0; i < 4; i++) m.cmd(1, 1, 1, 4'h0, {a[9:2], 2'(i)}, dv({a[9:2], 2'(i)}));
		m.cmd(1, 1, 0, 4'hf, a, '0);
		for (int i = 0; i < 4; i++) begin
			m.cmd(0, 0, 0, 4'hf, '0, '0);
			lo = il ? a[1:0] ^ 2'(i) : a[1:0] + 2'(i);
			check("burst", {1'b0, dv({a[9:2], lo})}, q);
		end
	endtask
	task automatic t_bytes;
		m.cmd(1, 1, 1, 4'h0, 10'h008, '1);
		m.cmd(0, 0, 1, 4'h0, '0, '1);
		m.cmd(1, 1, 1, 4'ha, 10'h008, '0);
		m.cmd(0, 0, 1, 4'hf, '0, '0);
		m.cmd(1, 1, 0, 4'hf, 10'h008, '0);
		m.stall;
		check("bytes", {5'h0a, 32'hff00ff00}, q);
		m.cmd(0, 0, 0, 4'hf, '0, '0);
		check("stall", {5'h0a, 32'hff00ff00}, q);
		m.cmd(1, 0, 0, 4'hf, '0, '0);
		check("advance", {1'b0, 36'hfffffffff}, q);
		m.cmd(1, 0, 0, 4'hf, '0, '0);
		check("deselect", 37'h1, 37'(q[36]));
	endtask
	task automatic t_oe_sleep;
		m.pins(1'b1, 1'b0);
		repeat (3) m.cmd(1, 0, 0, 4'hf, '0, '0);
		m.cmd(1, 1, 0, 4'hf, 10'h009, '0);
		m.cmd(1, 0, 0, 4'hf, '0, '0);
		check("oe_off", 37'h1, 37'(q[36]));
		m.pins(1'b0, 1'b1);
		repeat (8) m.cmd(1, 0, 0, 4'hf, '0, '0);
		check("asleep", 37'h1, 37'(sleeping));
		m.pins(1'b0, 1'b0);
		repeat (8) m.cmd(1, 0, 0, 4'hf, '0, '0);
		check("awake", 37'h0, 37'(sleeping));
		m.cmd(1, 1, 0, 4'hf, 10'h008, '0);
		m.cmd(1, 0, 0, 4'hf, '0, '0);
		check("kept", {5'h0a, 32'hff00ff00}, q);
	endtask
	task wrap_up;
		if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		#1 rst = 1'b0;
		check("reset", {1'b1, 36'h0}, q);
		check("flags", 37'h1, {35'h0, sleeping, buf_rdy});
		t_burst(10'h1f5, 1'b0);
		t_burst(10'h2a6, 1'b1);
		t_bytes;
		t_oe_sleep;
		wrap_up;
	end
endmodule

// File: src/flow_through_burst_sram_port.sv
// Purpose: device-side logic of a flow-through burst SRAM host port
// Assumes: one common clock; master drives all synchronous pins on it
// Notes: write beats queue in a 16-word buffer before reaching the array
// Notes on behaviour
// - read starts on qualified edge, selected, load
// - read data driven only while output enable low; here the pin passes two flops, so drive follows it two edges late
// - new operation accepted right after a read
// - deselect at edge tristates data at once
// - one address serves up to four beats
// - strap low linear, high interleaved order
// - counter touches only bits 1:0, wraps
// - advance ignores chip selects and write strobe
// - burst keeps direction captured at its start
// - write starts selected, strobe low, captures controls
// - data phase of write keeps pins tristated
// - write data taken next edge, new op allowed
// - only selected bytes and parity are updated
// - sleep entry and exit take two cycles
// - access pending at sleep entry is dropped
// - interleaved beat address is start xor index
// - linear beat address is start plus index
// - clock qualify pin high (clock enable low) freezes access state; synchronizers and sleep logic run on
// - comes out of reset deselected and tristated
`timescale 1ns/100ps
`include "sram_port_defs.svh"

module beat_fifo
	import sram_port_pkg::*;
#(
	parameter int W = 8,
	parameter int DEPTH = `SRAM_FIFO_DEPTH
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [W-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [W-1:0] o_data,
	output logic [DEPTH-1:0] o_live,
	output logic [DEPTH*W-1:0] o_window
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] store [DEPTH];
	logic [AW-1:0] rd_ptr;
	logic [AW-1:0] wr_ptr;
	logic [AW:0] count;
	wire push = i_valid & o_ready & i_ce;
	wire pop = o_valid & i_ready & i_ce;

	assign o_ready = (count != DEPTH[AW:0]);
	assign o_valid = (count != '0);
	assign o_data = store[rd_ptr];

	// entries exposed oldest first so the reader can overlay in age order
	genvar k;
	generate
		for (k = 0; k < DEPTH; k++) begin : g_win
			assign o_window[k*W +: W] = store[rd_ptr + AW'(k)];
			assign o_live[k] = (count > (AW+1)'(k));
		end
	endgenerate

	always_ff @(posedge i_sys_clk) begin
		if (push) begin
			store[wr_ptr] <= i_data;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			rd_ptr <= '0;
			wr_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule

module flow_through_burst_sram_port
	import sram_port_pkg::*;
#(
	parameter int ADDR_W = `SRAM_ADDR_W,
	parameter int FIFO_DEPTH = `SRAM_FIFO_DEPTH
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_clock_qualify_n,
	input wire logic i_chip_sel_a_n,
	input wire logic i_chip_sel_b,
	input wire logic i_chip_sel_c_n,
	input wire logic i_advance_or_load,
	input wire logic i_write_n,
	input wire logic [`SRAM_BYTES-1:0] i_byte_write_sel_n,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic i_out_enable_n,
	input wire logic i_sleep_request,
	input wire logic i_burst_order,
	input wire logic [8*`SRAM_BYTES-1:0] i_dq,
	output logic [8*`SRAM_BYTES-1:0] o_dq,
	output logic o_dq_oe_n,
	input wire logic [`SRAM_BYTES-1:0] i_parity_bus,
	output logic [`SRAM_BYTES-1:0] o_parity_bus,
	output logic o_parity_bus_oe_n,
	output logic o_sleeping,
	output logic o_wr_buf_ready
);
	localparam int BW = $bits(wr_beat_s);

	// asynchronous pins, two flops each
	logic oe_meta, oe_sync;
	logic slp_meta, slp_sync;
	logic mode_meta, mode_sync;

	sleep_state_e slp_state;
	logic [1:0] slp_cnt;

	logic burst_on;
	logic burst_wr;
	logic [ADDR_W-1:0] base_addr;
	logic [1:0] beat;

	logic pend_wr;
	logic [ADDR_W-1:0] pend_addr;
	logic [`SRAM_BYTES-1:0] pend_mask;

	logic rd_drive;
	word_t q_word;
	word_t read_word;
	word_t mem [2**ADDR_W];

	logic [FIFO_DEPTH-1:0] buf_live;
	logic [FIFO_DEPTH*BW-1:0] buf_window;
	logic buf_out_valid;
	wr_beat_s buf_out;
	wr_beat_s wr_beat;

	wire ce = ~i_clock_qualify_n;
	wire sleep_block = (slp_state != SLP_RUN);
	wire sel_all = ~i_chip_sel_a_n & i_chip_sel_b & ~i_chip_sel_c_n;
	wire load = ce & ~sleep_block & ~i_advance_or_load;
	wire advance = ce & ~sleep_block & i_advance_or_load;

	// beat address: only bits 1:0 move, upper bits stay from load
	wire [1:0] start_lo = base_addr[1:0];
	wire [1:0] beat_next = beat + 2'd1;
	wire [1:0] lo_linear = start_lo + beat_next;
	wire [1:0] lo_inter = start_lo ^ beat_next;
	wire [1:0] lo_next = (mode_sync == `SRAM_BURST_INTERLEAVED) ? lo_inter : lo_linear;
	wire [ADDR_W-1:0] burst_addr = {base_addr[ADDR_W-1:2], lo_next};

	access_s acc;
	assign acc.valid = load ? sel_all : (advance & burst_on);
	assign acc.write = load ? ~i_write_n : burst_wr;
	assign acc.addr = load ? i_addr : burst_addr;

	wire acc_read = acc.valid & ~acc.write;
	wire acc_wr = acc.valid & acc.write;

	word_t in_word;
	genvar b;
	generate
		for (b = 0; b < `SRAM_BYTES; b++) begin : g_lane
			assign in_word[b*`SRAM_LANE_W +: `SRAM_LANE_W] = {i_parity_bus[b], i_dq[b*8 +: 8]};
			assign o_dq[b*8 +: 8] = q_word[b*`SRAM_LANE_W +: 8];
			assign o_parity_bus[b] = q_word[b*`SRAM_LANE_W + 8];
		end
	endgenerate

	assign wr_beat.addr = pend_addr;
	assign wr_beat.mask = pend_mask;
	assign wr_beat.data = in_word;

	// a write with no byte selected is an abort and never enters the buffer
	wire buf_push = pend_wr & (|pend_mask) & ~sleep_block;
	wire buf_drain = ~sleep_block;

	beat_fifo #(
		.W(BW),
		.DEPTH(FIFO_DEPTH)
	) u_wr_buf (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_ce(ce),
		.i_valid(buf_push),
		.o_ready(o_wr_buf_ready),
		.i_data(wr_beat),
		.o_valid(buf_out_valid),
		.i_ready(buf_drain),
		.o_data(buf_out),
		.o_live(buf_live),
		.o_window(buf_window)
	);

	// read sees array, then queued beats oldest first, then the beat landing now
	always_comb begin
		wr_beat_s ent;
		ent = '0;
		read_word = mem[acc.addr];
		for (int k = 0; k < FIFO_DEPTH; k++) begin
			ent = buf_window[k*BW +: BW];
			if (buf_live[k] && ent.addr == acc.addr) begin
				for (int j = 0; j < `SRAM_BYTES; j++) begin
					if (ent.mask[j]) begin
						read_word[j*`SRAM_LANE_W +: `SRAM_LANE_W] =
							ent.data[j*`SRAM_LANE_W +: `SRAM_LANE_W];
					end
				end
			end
		end
		if (pend_wr && pend_addr == acc.addr) begin
			for (int j = 0; j < `SRAM_BYTES; j++) begin
				if (pend_mask[j]) begin
					read_word[j*`SRAM_LANE_W +: `SRAM_LANE_W] =
						in_word[j*`SRAM_LANE_W +: `SRAM_LANE_W];
				end
			end
		end
	end

	// array update from the buffer head; unselected lanes keep old bits
	always_ff @(posedge i_sys_clk) begin
		if (ce && buf_out_valid && buf_drain) begin
			for (int j = 0; j < `SRAM_BYTES; j++) begin
				if (buf_out.mask[j]) begin
					mem[buf_out.addr][j*`SRAM_LANE_W +: `SRAM_LANE_W] <=
						buf_out.data[j*`SRAM_LANE_W +: `SRAM_LANE_W];
				end
			end
		end
	end

	// sleep and output enable pins are unclocked, so not held by clock enable
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			oe_meta <= 1'b1;
			oe_sync <= 1'b1;
			slp_meta <= 1'b0;
			slp_sync <= 1'b0;
			mode_meta <= 1'b0;
			mode_sync <= 1'b0;
		end else begin
			oe_meta <= i_out_enable_n;
			oe_sync <= oe_meta;
			slp_meta <= i_sleep_request;
			slp_sync <= slp_meta;
			mode_meta <= i_burst_order;
			mode_sync <= mode_meta;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			slp_state <= SLP_RUN;
			slp_cnt <= '0;
		end else begin
			case (slp_state)
				SLP_RUN: begin
					slp_cnt <= '0;
					if (slp_sync) begin
						slp_state <= SLP_ENTER;
					end
				end
				SLP_ENTER: begin
					slp_cnt <= slp_cnt + 2'd1;
					if (!slp_sync) begin
						slp_state <= SLP_LEAVE;
						slp_cnt <= '0;
					end else if (slp_cnt == 2'(`SRAM_SLEEP_CYCLES - 1)) begin
						slp_state <= SLP_ASLEEP;
					end
				end
				SLP_ASLEEP: begin
					slp_cnt <= '0;
					if (!slp_sync) begin
						slp_state <= SLP_LEAVE;
					end
				end
				SLP_LEAVE: begin
					slp_cnt <= slp_cnt + 2'd1;
					if (slp_cnt == 2'(`SRAM_SLEEP_CYCLES - 1)) begin
						slp_state <= SLP_RUN;
					end
				end
				default: begin
					slp_state <= SLP_RUN;
					slp_cnt <= '0;
				end
			endcase
		end
	end

	assign o_sleeping = (slp_state == SLP_ASLEEP);

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			burst_on <= 1'b0;
			burst_wr <= 1'b0;
			base_addr <= '0;
			beat <= '0;
			pend_wr <= 1'b0;
			pend_addr <= '0;
			pend_mask <= '0;
			rd_drive <= 1'b0;
			q_word <= '0;
		end else if (sleep_block) begin
			burst_on <= 1'b0;
			pend_wr <= 1'b0;
			rd_drive <= 1'b0;
		end else if (ce) begin
			if (load) begin
				burst_on <= sel_all;
				burst_wr <= ~i_write_n;
				base_addr <= i_addr;
				beat <= '0;
			end else if (advance) begin
				beat <= beat_next;
			end
			pend_wr <= acc_wr;
			pend_addr <= acc.addr;
			pend_mask <= ~i_byte_write_sel_n;
			rd_drive <= acc_read;
			if (acc_read) begin
				q_word <= read_word;
			end
		end
	end

	assign o_dq_oe_n = ~(rd_drive & ~oe_sync);
	assign o_parity_bus_oe_n = o_dq_oe_n;
endmodule

// File: src/sram_port_defs.svh
// Purpose: shared constants of the flow-through burst SRAM port
// Assumes: included by bare name from package and design
// Notes: definitions only
`ifndef SRAM_PORT_DEFS_SVH
`define SRAM_PORT_DEFS_SVH

`define SRAM_ADDR_W 10
`define SRAM_BYTES 4
`define SRAM_LANE_W 9
`define SRAM_FIFO_DEPTH 16
`define SRAM_BURST_BEATS 4
`define SRAM_CLK_PERIOD_NS 4
`define SRAM_SLEEP_TIME_PERIODS 2
`define SRAM_SLEEP_CYCLES (`SRAM_SLEEP_TIME_PERIODS * `SRAM_CLK_PERIOD_NS / `SRAM_CLK_PERIOD_NS)
`define SRAM_BURST_LINEAR 1'b0
`define SRAM_BURST_INTERLEAVED 1'b1

`endif

// File: src/sram_port_pkg.sv
// Purpose: types of the flow-through burst SRAM port
// Assumes: sram_port_defs.svh holds the numbers
// Notes: one word lane is eight data bits plus one parity bit
`include "sram_port_defs.svh"

package sram_port_pkg;

	typedef logic [`SRAM_BYTES*`SRAM_LANE_W-1:0] word_t;

	typedef struct packed {
		logic [`SRAM_ADDR_W-1:0] addr;
		logic [`SRAM_BYTES-1:0] mask;
		word_t data;
	} wr_beat_s;

	typedef enum logic [1:0] {
		SLP_RUN,
		SLP_ENTER,
		SLP_ASLEEP,
		SLP_LEAVE
	} sleep_state_e;

	typedef struct packed {
		logic valid;
		logic write;
		logic [`SRAM_ADDR_W-1:0] addr;
	} access_s;

endpackage
